// *** rtl/ufsf_pkg.sv ***
package ufsf_pkg;
    localparam int unsigned QUEUE_DEPTH   = 256;
    localparam int unsigned CNT_W         = 9;
    localparam int unsigned CHAR_W        = 8;
    localparam int unsigned STATUS_W      = 8;
    // Channel status bit positions
    localparam int unsigned BIT_RX_WAIT   = 0;
    localparam int unsigned BIT_RX_FULL   = 1;
    localparam int unsigned BIT_TX_SPACE  = 2;
    localparam int unsigned BIT_OVERRUN   = 4;
    localparam logic [CNT_W-1:0]    CNT_FULL     = 9'h100;
    localparam logic [CNT_W-1:0]    CNT_RST      = 9'h000;
    localparam logic [STATUS_W-1:0] STATUS_RST   = 8'h04;
    localparam logic [CHAR_W-1:0]   CHAR_RST     = 8'h00;
    localparam logic [7:0]          PTR_RST      = 8'h00;
endpackage : ufsf_pkg

// *** rtl/ufsf_queue_mem.sv ***
`timescale 1ns/1ns
module ufsf_queue_mem
    import ufsf_pkg::*;
(
    // Clock
    input  wire logic              i_clk,
    // Write side
    input  wire logic              i_wr_en,
    input  wire logic [7:0]        i_wr_addr,
    input  wire logic [CHAR_W-1:0] i_wr_data,
    // Read side, registered data
    input  wire logic [7:0]        i_rd_addr,
    output logic      [CHAR_W-1:0] o_rd_data
);
    logic [CHAR_W-1:0] mem [QUEUE_DEPTH];

    // Write-first, so a push into an empty queue is readable at once
    always_ff @(posedge i_clk) begin
        if (i_wr_en) begin
            mem[i_wr_addr] <= i_wr_data;
        end
        if (i_wr_en && (i_wr_addr == i_rd_addr)) begin
            o_rd_data <= i_wr_data;
        end else begin
            o_rd_data <= mem[i_rd_addr];
        end
    end
endmodule : ufsf_queue_mem

// *** rtl/ufsf_status.sv ***
`timescale 1ns/1ns
module ufsf_status
    import ufsf_pkg::*;
(
    // Clock and reset
    input  wire logic                i_clk,
    input  wire logic                i_srst,
    // Configuration
    input  wire logic                i_tx_enable,
    input  wire logic [CNT_W-1:0]    i_tx_fill_level_setting,
    // Host transmit queue writes
    input  wire logic                i_tx_wr,
    input  wire logic [CHAR_W-1:0]   i_tx_wr_data,
    // Serializer side of transmit queue
    input  wire logic                i_tx_take,
    output logic                     o_tx_char_valid,
    output logic      [CHAR_W-1:0]   o_tx_char,
    // Deserializer side
    input  wire logic                i_rx_char_done,
    input  wire logic [CHAR_W-1:0]   i_rx_char,
    input  wire logic                i_rx_start_bit,
    input  wire logic                i_clr_overrun,
    // Host receive queue reads
    input  wire logic                i_rx_rd,
    output logic      [CHAR_W-1:0]   o_rx_rd_data,
    // Status
    output logic      [STATUS_W-1:0] o_channel_status,
    output logic      [CNT_W-1:0]    o_tx_count,
    output logic      [CNT_W-1:0]    o_rx_count
);
    // Transmit queue state
    logic [CNT_W-1:0]  tx_cnt_ff, nxt_tx_cnt;
    logic [7:0]        tx_wp_ff,  nxt_tx_wp;
    logic [7:0]        tx_rp_ff,  nxt_tx_rp;
    // Receive queue state
    logic [CNT_W-1:0]  rx_cnt_ff, nxt_rx_cnt;
    logic [7:0]        rx_wp_ff,  nxt_rx_wp;
    logic [7:0]        rx_rp_ff,  nxt_rx_rp;
    logic              hold_vld_ff, nxt_hold_vld;
    logic [CHAR_W-1:0] hold_ff,   nxt_hold;
    // Flags
    logic              rx_full_ff, nxt_rx_full;
    logic              rx_wait_ff, nxt_rx_wait;
    logic              ovr_ff,     nxt_ovr;
    logic              tx_space_ff, nxt_tx_space;

    logic              tx_push, tx_pop;
    logic              rx_push, rx_pop;
    logic [CHAR_W-1:0] rx_push_data;
    logic [CHAR_W-1:0] tx_mem_q;
    // Occupancy decode
    logic              tx_at_full, tx_at_empty;
    logic              rx_at_full, rx_at_empty;

    // Empty and full decode of the registered counts
    always_comb begin
        tx_at_full  = (tx_cnt_ff == CNT_FULL);
        tx_at_empty = (tx_cnt_ff == CNT_RST);
        rx_at_full  = (rx_cnt_ff == CNT_FULL);
        rx_at_empty = (rx_cnt_ff == CNT_RST);
    end

    // Transmit queue
    always_comb begin
        // Writes into a full queue are refused
        tx_push    = i_tx_wr && !tx_at_full;
        // Disabled transmitter drains nothing; stale characters are flushed
        tx_pop     = i_tx_take && i_tx_enable && !tx_at_empty;
        nxt_tx_wp  = tx_push ? tx_wp_ff + 8'h01 : tx_wp_ff;
        nxt_tx_rp  = tx_pop  ? tx_rp_ff + 8'h01 : tx_rp_ff;
        nxt_tx_cnt = tx_cnt_ff;
        if (tx_push && !tx_pop) begin
            nxt_tx_cnt = tx_cnt_ff + 9'h001;
        end else if (tx_pop && !tx_push) begin
            nxt_tx_cnt = tx_cnt_ff - 9'h001;
        end
        if (!i_tx_enable) begin
            nxt_tx_cnt = CNT_RST;
            nxt_tx_rp  = nxt_tx_wp;
        end
        // Space while below full and not above threshold
        nxt_tx_space = (nxt_tx_cnt != CNT_FULL)
                       && (nxt_tx_cnt <= i_tx_fill_level_setting);
    end

    // Receive queue with one holding character behind it
    always_comb begin
        rx_pop       = i_rx_rd && !rx_at_empty;
        rx_push      = 1'b0;
        rx_push_data = i_rx_char;
        nxt_hold_vld = hold_vld_ff;
        nxt_hold     = hold_ff;
        nxt_ovr      = ovr_ff;
        if (hold_vld_ff && rx_pop) begin
            // Waiting character loads at once on the read
            rx_push      = 1'b1;
            rx_push_data = hold_ff;
            nxt_hold_vld = 1'b0;
            // A character arriving with this read is dropped
        end else if (i_rx_char_done) begin
            if (!rx_at_full || rx_pop) begin
                rx_push = 1'b1;
            end else if (!hold_vld_ff) begin
                nxt_hold_vld = 1'b1;
                nxt_hold     = i_rx_char;
            end
        end
        if (i_rx_start_bit && hold_vld_ff && !rx_pop && rx_at_full) begin
            nxt_ovr      = 1'b1;
            nxt_hold_vld = 1'b0;
        end else if (i_clr_overrun) begin
            nxt_ovr = 1'b0;
        end
        nxt_rx_wp  = rx_push ? rx_wp_ff + 8'h01 : rx_wp_ff;
        nxt_rx_rp  = rx_pop  ? rx_rp_ff + 8'h01 : rx_rp_ff;
        // Push and pop together leave the count as it is
        nxt_rx_cnt = rx_cnt_ff;
        if (rx_push && !rx_pop) begin
            nxt_rx_cnt = rx_cnt_ff + 9'h001;
        end else if (rx_pop && !rx_push) begin
            nxt_rx_cnt = rx_cnt_ff - 9'h001;
        end
        // Set wins over clear on both flags
        nxt_rx_full = rx_full_ff;
        if (rx_push && nxt_rx_cnt == CNT_FULL) begin
            nxt_rx_full = 1'b1;
        end else if (rx_pop && nxt_rx_cnt != CNT_FULL) begin
            nxt_rx_full = 1'b0;
        end
        nxt_rx_wait = rx_wait_ff;
        if (rx_push) begin
            nxt_rx_wait = 1'b1;
        end else if (rx_pop && nxt_rx_cnt == CNT_RST) begin
            nxt_rx_wait = 1'b0;
        end
    end

    // Transmit queue registers
    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            tx_cnt_ff   <= CNT_RST;
            tx_wp_ff    <= PTR_RST;
            tx_rp_ff    <= PTR_RST;
            tx_space_ff <= STATUS_RST[BIT_TX_SPACE];
        end else begin
            tx_cnt_ff   <= nxt_tx_cnt;
            tx_wp_ff    <= nxt_tx_wp;
            tx_rp_ff    <= nxt_tx_rp;
            tx_space_ff <= nxt_tx_space;
        end
    end

    // Receive queue and flag registers
    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            rx_cnt_ff   <= CNT_RST;
            rx_wp_ff    <= PTR_RST;
            rx_rp_ff    <= PTR_RST;
            hold_vld_ff <= 1'b0;
            hold_ff     <= CHAR_RST;
            rx_full_ff  <= STATUS_RST[BIT_RX_FULL];
            rx_wait_ff  <= STATUS_RST[BIT_RX_WAIT];
            ovr_ff      <= STATUS_RST[BIT_OVERRUN];
        end else begin
            rx_cnt_ff   <= nxt_rx_cnt;
            rx_wp_ff    <= nxt_rx_wp;
            rx_rp_ff    <= nxt_rx_rp;
            hold_vld_ff <= nxt_hold_vld;
            hold_ff     <= nxt_hold;
            rx_full_ff  <= nxt_rx_full;
            rx_wait_ff  <= nxt_rx_wait;
            ovr_ff      <= nxt_ovr;
        end
    end

    // Read address looks ahead so data is ready the cycle after a pop
    ufsf_queue_mem u_tx_mem (
        .i_clk     (i_clk),
        .i_wr_en   (tx_push),
        .i_wr_addr (tx_wp_ff),
        .i_wr_data (i_tx_wr_data),
        .i_rd_addr (nxt_tx_rp),
        .o_rd_data (tx_mem_q)
    );

    ufsf_queue_mem u_rx_mem (
        .i_clk     (i_clk),
        .i_wr_en   (rx_push),
        .i_wr_addr (rx_wp_ff),
        .i_wr_data (rx_push_data),
        .i_rd_addr (nxt_rx_rp),
        .o_rd_data (o_rx_rd_data)
    );

    // Both memories forward a write aimed at the slot being read, so head
    // data is ready in the first cycle the count shows it; without that the
    // serializer could take a stale character
    assign o_tx_char       = tx_mem_q;
    assign o_tx_char_valid = i_tx_enable && !tx_at_empty;
    assign o_tx_count      = tx_cnt_ff;
    assign o_rx_count      = rx_cnt_ff;

    // No status write path exists; reads have no side effect
    always_comb begin
        o_channel_status               = '0;
        o_channel_status[BIT_RX_WAIT]  = rx_wait_ff;
        o_channel_status[BIT_RX_FULL]  = rx_full_ff;
        o_channel_status[BIT_TX_SPACE] = tx_space_ff;
        o_channel_status[BIT_OVERRUN]  = ovr_ff;
    end
endmodule : ufsf_status

// *** bench/ufsf_status_chk.sv ***
`timescale 1ns/1ns
module ufsf_chk
    import ufsf_pkg::*;
(
    input  wire logic                i_clk,
    input  wire logic                i_srst,
    input  wire logic                i_tx_enable,
    input  wire logic [CNT_W-1:0]    i_tx_fill_level_setting,
    input  wire logic                i_rx_char_done,
    input  wire logic                i_rx_start_bit,
    input  wire logic                i_rx_rd,
    input  wire logic [STATUS_W-1:0] o_channel_status,
    input  wire logic [CNT_W-1:0]    o_tx_count,
    input  wire logic [CNT_W-1:0]    o_rx_count
);
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (i_srst);
    tx_space_a: assert property ($stable(i_tx_fill_level_setting) |-> o_channel_status[2] ==
        (o_tx_count != CNT_FULL && o_tx_count <= i_tx_fill_level_setting)) else $error("tx space flag wrong");
    tx_flush_a: assert property (!i_tx_enable |=> o_tx_count == CNT_RST) else $error("tx queue kept");
    rx_wait_a: assert property (o_channel_status[0] == (o_rx_count != CNT_RST)) else $error("rx wait");
    rx_full_a: assert property (o_channel_status[1] == (o_rx_count == CNT_FULL)) else $error("rx full");
    rx_fill_a: assert property (i_rx_char_done && o_rx_count == CNT_RST |=> o_rx_count == 9'h001)
        else $error("rx first char");
    rx_hold_a: assert property (i_rx_char_done && o_rx_count == CNT_FULL && !i_rx_rd && !i_rx_start_bit
        ##1 !i_rx_rd && !i_rx_start_bit ##1 i_rx_rd |=> o_channel_status[1]) else $error("hold refill");
    overrun_a: assert property (i_rx_char_done && o_rx_count == CNT_FULL && !i_rx_rd
        ##1 !i_rx_rd ##1 i_rx_start_bit && !i_rx_rd |=> o_channel_status[4]) else $error("no overrun");
    rx_quiet_a: assert property (!i_rx_char_done && !i_rx_rd |=> $stable(o_rx_count))
        else $error("rx count moved");
    spare_bits_a: assert property (o_channel_status[7:5] == 3'h0 && !o_channel_status[3])
        else $error("spare status bit");
endmodule : ufsf_chk
bind ufsf_status ufsf_chk u_chk (.i_clk(i_clk), .i_srst(i_srst), .i_tx_enable(i_tx_enable),
    .i_tx_fill_level_setting(i_tx_fill_level_setting), .i_rx_char_done(i_rx_char_done),
    .i_rx_start_bit(i_rx_start_bit), .i_rx_rd(i_rx_rd), .o_channel_status(o_channel_status),
    .o_tx_count(o_tx_count), .o_rx_count(o_rx_count));

// *** bench/ufsf_host_model.sv ***
`timescale 1ns/1ns
module ufsf_host_model
    import ufsf_pkg::*;
(
    input  wire logic              i_clk,
    output logic                   o_tx_wr,
    output logic      [CHAR_W-1:0] o_tx_wr_data,
    output logic                   o_rx_rd
);
    initial {o_tx_wr, o_tx_wr_data, o_rx_rd} = '0;
    // One access per two clocks, so head data is settled before the next one
    task automatic wr(input logic [CHAR_W-1:0] d);
        @(negedge i_clk) {o_tx_wr, o_tx_wr_data} = {1'b1, d};
        @(negedge i_clk) {o_tx_wr, o_tx_wr_data} = {1'b0, ~d};
    endtask : wr
    task automatic rd();
        @(negedge i_clk) o_rx_rd = 1'b1;
        @(negedge i_clk) o_rx_rd = 1'b0;
    endtask : rd
endmodule : ufsf_host_model

// *** bench/uart_fifo_status_flags_tb.sv ***
`timescale 1ns/1ns
`define CHK(n, e, a) begin exp_v = 32'(e); comparisons++; \
    if (32'(a) !== exp_v) begin err_count++; $display("CHECK FAILED %s exp %0h got %0h", n, exp_v, a); end end
module uart_fifo_status_flags_tb
    import ufsf_pkg::*;
;
    logic                clk = 0, srst = 1, tx_en = 1, take = 0, done = 0, start = 0, clr = 0, wr, rd, txv;
    logic [CNT_W-1:0]    fill = 9'h0ff, txc, rxc;
    logic [CHAR_W-1:0]   rch = 8'h00, wd, txd, rxd;
    logic [STATUS_W-1:0] st;
    logic [CHAR_W-1:0]   txq[$], rxq[$];
    logic [31:0]         seed = 32'h53, exp_v;
    int                  err_count = 0, comparisons = 0;
    always #50 clk = ~clk;
    ufsf_status u_dut (.i_clk(clk), .i_srst(srst), .i_tx_enable(tx_en), .i_tx_fill_level_setting(fill),
        .i_tx_wr(wr), .i_tx_wr_data(wd), .i_tx_take(take), .o_tx_char_valid(txv), .o_tx_char(txd),
        .i_rx_char_done(done), .i_rx_char(rch), .i_rx_start_bit(start), .i_clr_overrun(clr), .i_rx_rd(rd),
        .o_rx_rd_data(rxd), .o_channel_status(st), .o_tx_count(txc), .o_rx_count(rxc));
    ufsf_host_model u_host (.i_clk(clk), .o_tx_wr(wr), .o_tx_wr_data(wd), .o_rx_rd(rd));
    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction : rnd
    task automatic rx_in(input int n);
        repeat (n) begin
            @(negedge clk) {done, rch} = {1'b1, 8'(rnd())};
            rxq.push_back(rch);
            @(negedge clk) {done, rch} = {1'b0, ~rch};
        end
    endtask : rx_in
    task automatic stop_test();
        $display("Comparisons %0d, errors %0d", comparisons, err_count);
        if (err_count == 0 && comparisons > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask : stop_test
    // Results in queue order, whenever a character is taken from the transmit queue or read from the receive queue
    always @(posedge clk) begin
        if (take && txv) `CHK("tx char", txq.pop_front(), txd)
        if (rd && rxc != 0) `CHK("rx char", rxq.pop_front(), rxd)
    end
    initial begin
        #1000000;
        err_count++;
        stop_test();
    end
    initial begin
        logic [CHAR_W-1:0] d;
        repeat (4) @(negedge clk);
        srst = 0;
        `CHK("status", STATUS_RST, st)
        fill = 9'h002;
        for (int i = 1; i <= 3; i++) begin
            d = 8'(rnd());
            txq.push_back(d);
            u_host.wr(d);
            `CHK("tx space", i < 3, st[2])
        end
        repeat (3) begin
            @(negedge clk) take = 1;
            @(negedge clk) take = 0;
            repeat (rnd() % 3) @(negedge clk);
        end
        fill = 9'h0ff;
        repeat (257) u_host.wr(8'(rnd()));
        `CHK("tx count", CNT_FULL, txc)
        `CHK("tx space", 1'b0, st[2])
        @(negedge clk) tx_en = 0;
        u_host.wr(8'(rnd()));
        `CHK("tx valid", 1'b0, txv)
        tx_en = 1;
        @(negedge clk) `CHK("tx count", CNT_RST, txc)
        `CHK("tx valid", 1'b0, txv)
        d = 8'(rnd());
        txq.push_back(d);
        u_host.wr(d);
        take = 1;
        @(negedge clk) take = 0;
        `CHK("tx space", 1'b1, st[2])
        rx_in(1);
        `CHK("rx wait", 1'b1, st[0])
        u_host.rd();
        `CHK("rx wait", 1'b0, st[0])
        rx_in(255);
        `CHK("rx full", 1'b0, st[1])
        rx_in(2);
        `CHK("rx full", 1'b1, st[1])
        u_host.rd();
        `CHK("rx full", 1'b1, st[1])
        u_host.rd();
        `CHK("rx full", 1'b0, st[1])
        rx_in(2);
        @(negedge clk) start = 1;
        @(negedge clk) start = 0;
        void'(rxq.pop_back());
        `CHK("overrun", 1'b1, st[4])
        clr = 1;
        @(negedge clk) clr = 0;
        `CHK("overrun", 1'b0, st[4])
        repeat (256) u_host.rd();
        `CHK("rx wait", 1'b0, st[0])
        rx_in(1);
        srst = 1;
        @(negedge clk) srst = 0;
        `CHK("status", STATUS_RST, st)
        stop_test();
    end
endmodule : uart_fifo_status_flags_tb
